/* File: hdl/agc_map.svh */
// Offsets, field positions, reset values and timing counts of the gain control loop
// What this block does
// - Four-bit attack code sets raw loop bandwidth
// - Each attack step raises bandwidth by root two
// - Attack time is 35 over attack bandwidth
// - Four-bit decay code sets decay to attack ratio
// - Each decay step multiplies decay by root two
// - Three-bit code sets attenuation per reset event
// - Each reset code step doubles event weighting
// - Reset ramps 12 dB in 10 us to 1.2 ms
// - Fast-acquire bit lowers DAC source resistance
// - Digital gain steered by larger of two estimates
// - Digital gain stage multiplies by one to four
// - Gain four drops two top bits, keeps sixteen
// - Gain one outputs top sixteen of 24 bits
// - Beyond unity digital gain, raise analog attenuation
// - Noise-shape 24-bit data before 16-bit truncation
// - Reference code zero manual, one to seven levels
// - Loop runs at one sixtieth of converter clock
// - Level estimate is sum of absolute I and Q
// - Up step from attack, down from attack minus decay
`ifndef AGC_MAP_SVH
`define AGC_MAP_SVH
`define AGC_REG_MIXER_ATTENUATOR_ENABLE        8'h03
`define AGC_REG_GAIN_LO      8'h04
`define AGC_REG_RATE         8'h05
`define AGC_REG_CTRL         8'h06
`define AGC_RST_MIXER_ATTENUATOR_ENABLE        8'h00
`define AGC_RST_GAIN_LO      8'h00
`define AGC_RST_RATE         8'h00
`define AGC_RST_CTRL         8'h00
`define AGC_MIXATT_BIT       7
`define AGC_ATTACK_MSB       7
`define AGC_ATTACK_LSB       4
`define AGC_DECAY_MSB        3
`define AGC_DECAY_LSB        0
`define AGC_DGEN_BIT         7
`define AGC_RSTR_MSB         6
`define AGC_RSTR_LSB         4
`define AGC_FAST_BIT         3
`define AGC_REF_MSB          2
`define AGC_REF_LSB          0
`define AGC_LOOP_DIV         60
`define AGC_FCLK_REF_HZ      18000000
`define AGC_BW_MIN_HZ        50
`define AGC_ATTACK_K         35
`define AGC_ATTACK_CYC       ((`AGC_ATTACK_K * `AGC_FCLK_REF_HZ) / `AGC_BW_MIN_HZ)
`define AGC_RST_RAMP_HIGH_US 10
`define AGC_RST_RAMP_LOW_US  1200
`define AGC_RST_LOW_CYC      (`AGC_RST_RAMP_LOW_US * (`AGC_FCLK_REF_HZ / 1000000))
`define AGC_CLIP_LEVEL       17'h0cb59
`define AGC_ANALOG_SPAN      15'h4000
`define AGC_GAIN_UNITY       16'h1000
`define AGC_GAIN_FOUR        16'h4000
`define AGC_FRAC_BITS        9
`endif

/* File: hdl/agc_pkg.sv */
// Types shared by the gain control loop files
package agc_pkg;
  typedef enum logic [2:0] {
    AGC_ST_WAIT  = 3'b001,
    AGC_ST_CMP   = 3'b010,
    AGC_ST_APPLY = 3'b100
  } agc_state_t;
  typedef logic signed [23:0] agc_samp_t;
  typedef logic signed [15:0] agc_out_t;
  typedef logic [14:0]        agc_word_t;
endpackage

/* File: hdl/agc_fifo.sv */
// Output sample FIFO with registered read data
`timescale 1ns/1ps
module agc_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH = (AW+1)'(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  // Pop refills the output register whenever data is stored and the register is empty or being taken
  assign push     = in_valid & in_ready;
  assign pop      = (cnt_reg != '0) & (~out_valid | out_ready);
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

  // Storage array, no reset needed
  always_ff @(posedge clk_sys)
    if (push)
      mem[wp_reg] <= in_data;

  // Pointers, count and a registered full flag
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      wp_reg   <= '0;
      rp_reg   <= '0;
      cnt_reg  <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      wp_reg   <= push ? AW'(wp_reg + 1'b1) : wp_reg;
      rp_reg   <= pop ? AW'(rp_reg + 1'b1) : rp_reg;
      cnt_reg  <= cnt_next;
      in_ready <= cnt_next < DEPTH;
    end

  // Read data comes out of a register
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data  <= mem[rp_reg];
    end
    else if (out_ready)
      out_valid <= 1'b0;
endmodule

/* File: hdl/agc_nshape.sv */
// First-order error-feedback truncation from 24 to 16 bits
`timescale 1ns/1ps
module agc_nshape (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              adv,
  input  wire logic              in_valid,
  input  wire agc_pkg::agc_samp_t in_data,
  output logic                   out_valid,
  output agc_pkg::agc_out_t      out_data
);
  import agc_pkg::*;
  logic [7:0]         err_reg;
  logic signed [24:0] sum;
  agc_out_t           trunc;

  // Feed back the dropped fraction; pushes noise out of band
  always_comb
  begin
    sum   = 25'(in_data) + 25'($signed({1'b0, err_reg}));
    trunc = sum[23:8];
    if (sum[24] != sum[23])
      trunc = sum[24] ? 16'sh8000 : 16'sh7fff;
  end

  // Hold everything while the FIFO stalls
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
      err_reg   <= '0;
    end
    else if (adv)
    begin
      out_valid <= in_valid;
      if (in_valid)
      begin
        out_data <= trunc;
        err_reg  <= (sum[24] != sum[23]) ? 8'h00 : sum[7:0];
      end
    end
endmodule

/* File: hdl/agc_loop_top.sv */
// Gain control loop, digital gain stage and 16-bit output path
`timescale 1ns/1ps
`include "agc_map.svh"
module agc_loop_top #(
  parameter int ATTACK_CYC_A0 = `AGC_ATTACK_CYC,
  parameter int RST_LOW_CYC   = `AGC_RST_LOW_CYC,
  parameter int FIFO_DEPTH    = 32
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               reg_wr_en,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic [7:0]              reg_rdata,
  input  wire logic               first_decimation_stage_valid,
  input  wire logic signed [15:0] first_decimation_stage_i,
  input  wire logic signed [15:0] first_decimation_stage_q,
  input  wire logic               adc_reset_evt,
  input  wire logic               samp_in_valid,
  input  wire agc_pkg::agc_samp_t samp_in_i,
  input  wire agc_pkg::agc_samp_t samp_in_q,
  output logic                    samp_in_ready,
  output logic                    out_valid,
  output agc_pkg::agc_out_t       out_i,
  output agc_pkg::agc_out_t       out_q,
  input  wire logic               out_ready,
  output logic [7:0]              gain_dac_code,
  output logic                    fast_acquire_out,
  output logic                    mixer_mixer_attenuator_enable_out
);
  import agc_pkg::*;
  localparam logic [23:0] ACC_MAX = 24'hffffff;
  localparam logic [47:0] STEP0   = 48'((48'(ACC_MAX) * `AGC_LOOP_DIV) / ATTACK_CYC_A0);
  localparam logic [23:0] RSTW0   = 24'((48'(ACC_MAX) * `AGC_LOOP_DIV) / RST_LOW_CYC);

  logic [7:0]  mixer_attenuator_enable_reg;
  logic [7:0]  gain_lo_reg;
  logic [7:0]  rate_reg;
  logic [7:0]  ctrl_reg;
  logic [5:0]  div_reg;
  logic        tick_reg;
  logic [16:0] est1_reg;
  logic [16:0] est2_reg;
  logic [16:0] est_sel_reg;
  logic [16:0] ref_reg;
  logic        rst_pend_reg;
  agc_state_t  state_reg;
  agc_state_t  state_next;
  logic [23:0] acc_reg;
  logic [23:0] acc_next;
  logic [23:0] step_up;
  logic [23:0] step_dn;
  logic [23:0] rst_w;
  logic [15:0] g_reg;
  logic [13:0] analog_reg;
  agc_samp_t   s1_data [2];
  logic        s1_valid;
  logic [1:0]  s2_valid;
  agc_out_t    s2_data [2];
  logic        adv;
  logic        fifo_push;
  logic [3:0]  attack;
  logic [3:0]  decay;
  logic [2:0]  rst_code;
  logic [2:0]  ref_code;
  logic        dg_en;
  logic        agc_on;
  agc_word_t   att_word;
  agc_word_t   man_word;

  // Field views of the control registers
  assign attack   = rate_reg[`AGC_ATTACK_MSB:`AGC_ATTACK_LSB];
  assign decay    = rate_reg[`AGC_DECAY_MSB:`AGC_DECAY_LSB];
  assign rst_code = ctrl_reg[`AGC_RSTR_MSB:`AGC_RSTR_LSB];
  assign ref_code = ctrl_reg[`AGC_REF_MSB:`AGC_REF_LSB];
  assign dg_en    = ctrl_reg[`AGC_DGEN_BIT];
  assign agc_on   = ref_code != 3'h0;
  assign man_word = {mixer_attenuator_enable_reg[6:0], gain_lo_reg};
  assign att_word = acc_reg[23:`AGC_FRAC_BITS];

  // Magnitude of a 16-bit sample, used by both level estimates
  function automatic logic [15:0] agc_abs16(input logic signed [15:0] x);
    logic [16:0] m;
    m = x[15] ? 17'(-$signed({x[15], x})) : 17'({1'b0, x});
    return m[16] ? 16'hffff : m[15:0];
  endfunction

  // Loop step for a half-octave exponent h: STEP0 scaled by root two per unit
  function automatic logic [23:0] agc_step(input logic signed [5:0] h);
    logic [5:0]  hh;
    logic [47:0] v;
    hh = 6'(h + 6'sd16);
    v  = (hh[0] ? 48'd181 : 48'd128) << hh[4:1];
    v  = (v * STEP0) >> 15;
    return (v == '0) ? 24'h000001 : ((v > 48'(ACC_MAX)) ? ACC_MAX : v[23:0]);
  endfunction

  // Gain multiply, rescaled and clamped back to 24 bits
  function automatic agc_samp_t agc_gain(input agc_samp_t x, input logic [15:0] g);
    logic signed [40:0] p;
    p = (41'(x) * $signed({1'b0, g})) >>> 12;
    if (p > 41'sh7fffff)
      return 24'sh7fffff;
    if (p < -41'sh800000)
      return 24'sh800000;
    return p[23:0];
  endfunction

  // Register port: writes store, reads are registered; unmapped reads return zero
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      mixer_attenuator_enable_reg   <= `AGC_RST_MIXER_ATTENUATOR_ENABLE;
      gain_lo_reg <= `AGC_RST_GAIN_LO;
      rate_reg    <= `AGC_RST_RATE;
      ctrl_reg    <= `AGC_RST_CTRL;
    end
    else if (reg_wr_en)
      case (reg_addr)
        `AGC_REG_MIXER_ATTENUATOR_ENABLE:   mixer_attenuator_enable_reg   <= reg_wdata;
        `AGC_REG_GAIN_LO: gain_lo_reg <= reg_wdata;
        `AGC_REG_RATE:    rate_reg    <= reg_wdata;
        `AGC_REG_CTRL:    ctrl_reg    <= reg_wdata;
        default:          ;
      endcase

  // Readback shows the live attenuation word, not just what was written
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      reg_rdata <= 8'h00;
    else
      case (reg_addr)
        `AGC_REG_MIXER_ATTENUATOR_ENABLE:   reg_rdata <= {mixer_attenuator_enable_reg[`AGC_MIXATT_BIT], att_word[14:8]};
        `AGC_REG_GAIN_LO: reg_rdata <= att_word[7:0];
        `AGC_REG_RATE:    reg_rdata <= rate_reg;
        `AGC_REG_CTRL:    reg_rdata <= ctrl_reg;
        default:          reg_rdata <= 8'h00;
      endcase

  // Loop rate divider; one tick every sixty clocks
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      div_reg  <= 6'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      div_reg  <= (div_reg == 6'(`AGC_LOOP_DIV - 1)) ? 6'h00 : 6'(div_reg + 1'b1);
      tick_reg <= div_reg == 6'(`AGC_LOOP_DIV - 1);
    end

  // Level estimates after first decimation and after the gain stage
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      est1_reg <= 17'h00000;
      est2_reg <= 17'h00000;
    end
    else
    begin
      if (first_decimation_stage_valid)
        est1_reg <= 17'(agc_abs16(first_decimation_stage_i)) + 17'(agc_abs16(first_decimation_stage_q));
      if (fifo_push)
        est2_reg <= 17'(agc_abs16(s2_data[0])) + 17'(agc_abs16(s2_data[1]));
    end

  // Reset events pend until the next loop update; a new event beats the clear
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      rst_pend_reg <= 1'b0;
    else if (adc_reset_evt)
      rst_pend_reg <= 1'b1;
    else if (state_reg == AGC_ST_APPLY)
      rst_pend_reg <= 1'b0;

  // Loop sequencer: compare on the tick, apply one cycle later
  always_comb
    case (state_reg)
      AGC_ST_WAIT:  state_next = tick_reg ? AGC_ST_CMP : AGC_ST_WAIT;
      AGC_ST_CMP:   state_next = AGC_ST_APPLY;
      AGC_ST_APPLY: state_next = AGC_ST_WAIT;
      default:      state_next = AGC_ST_WAIT;
    endcase

  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      state_reg <= AGC_ST_WAIT;
    else
      state_reg <= state_next;

  // Select estimate and reference level; root two per 3 dB step
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      est_sel_reg <= 17'h00000;
      ref_reg     <= 17'h00000;
    end
    else if (state_reg == AGC_ST_CMP)
    begin
      est_sel_reg <= (dg_en && est2_reg > est1_reg) ? est2_reg : est1_reg;
      ref_reg     <= 17'(((25'(`AGC_CLIP_LEVEL) * (ref_code[0] ? 25'd181 : 25'd256))
                          >> 8) >> ref_code[2:1]);
    end

  // Step sizes: attack sets both directions, decay slows the way down
  assign step_up = agc_step($signed({2'b00, attack}));
  assign step_dn = agc_step(6'($signed({2'b00, attack}) - $signed({2'b00, decay})));
  assign rst_w   = ((32'(RSTW0) << rst_code) > 32'(ACC_MAX)) ? ACC_MAX
                 : 24'(RSTW0 << rst_code);

  // Next attenuation with clamping; overshoot would flip gain direction
  always_comb
  begin
    logic signed [26:0] sum;
    sum = $signed({3'b000, acc_reg});
    if (est_sel_reg > ref_reg)
      sum = sum + $signed({3'b000, step_up});
    else if (est_sel_reg < ref_reg)
      sum = sum - $signed({3'b000, step_dn});
    if (rst_pend_reg)
      sum = sum + $signed({3'b000, rst_w});
    if (sum < 27'sd0)
      acc_next = 24'h000000;
    else if (sum > $signed({3'b000, ACC_MAX}))
      acc_next = ACC_MAX;
    else
      acc_next = sum[23:0];
  end

  // Manual mode follows the written word; automatic mode updates per loop tick
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      acc_reg <= 24'h000000;
    else if (!agc_on)
      acc_reg <= {man_word, {`AGC_FRAC_BITS{1'b0}}};
    else if (state_reg == AGC_ST_APPLY)
      acc_reg <= acc_next;
  // Split attenuation with digital gain on: low half trims digital gain, high half drives analog path; off, all drives analog
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      g_reg      <= `AGC_GAIN_UNITY;
      analog_reg <= 14'h0000;
    end
    else if (dg_en && att_word < `AGC_ANALOG_SPAN)
    begin
      g_reg      <= `AGC_GAIN_FOUR - 16'((17'(att_word) * 17'd3) >> 2);
      analog_reg <= 14'h0000;
    end
    else
    begin
      g_reg      <= `AGC_GAIN_UNITY;
      analog_reg <= dg_en ? 14'(att_word - `AGC_ANALOG_SPAN)
                  : (att_word[14] ? 14'h3fff : att_word[13:0]);
    end

  // Pins toward the gain DAC, its resistance switch and the mixer attenuator
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      gain_dac_code    <= 8'h00;
      fast_acquire_out <= 1'b0;
      mixer_mixer_attenuator_enable_out  <= 1'b0;
    end
    else
    begin
      gain_dac_code    <= analog_reg[13:6];
      fast_acquire_out <= ctrl_reg[`AGC_FAST_BIT];
      mixer_mixer_attenuator_enable_out  <= mixer_attenuator_enable_reg[`AGC_MIXATT_BIT];
    end

  // Gain stage; whole pipeline stalls with the FIFO so nothing is dropped
  assign adv = samp_in_ready;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      s1_valid   <= 1'b0;
      s1_data[0] <= '0;
      s1_data[1] <= '0;
    end
    else if (adv)
    begin
      s1_valid   <= samp_in_valid;
      s1_data[0] <= agc_gain(samp_in_i, g_reg);
      s1_data[1] <= agc_gain(samp_in_q, g_reg);
    end

  // One shaper per channel, then the top sixteen bits
  for (genvar c = 0; c < 2; c++)
  begin : g_shape
    agc_nshape u_shape (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .adv       (adv),
      .in_valid  (s1_valid),
      .in_data   (s1_data[c]),
      .out_valid (s2_valid[c]),
      .out_data  (s2_data[c])
    );
  end

  assign fifo_push = s2_valid[0] & samp_in_ready;

  // Output buffer; I in the high half, Q in the low half
  agc_fifo #(
    .W (32),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (s2_valid[0]),
    .in_data   ({s2_data[0], s2_data[1]}),
    .in_ready  (samp_in_ready),
    .out_valid (out_valid),
    .out_data  ({out_i, out_q}),
    .out_ready (out_ready)
  );

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_tick_period: assert property (tick_reg |-> ##60 tick_reg)
    else $error("loop tick not every sixty clocks");
  a_tick_gap: assert property (tick_reg |=> !tick_reg [*8])
    else $error("loop tick repeated too soon");
  a_manual_follow: assert property (!agc_on ##1 !agc_on |-> att_word == $past(man_word))
    else $error("manual word not followed");
  a_step_up: assert property (state_reg == AGC_ST_APPLY && agc_on && !rst_pend_reg
      && est_sel_reg > ref_reg && acc_reg <= ACC_MAX - step_up
      |=> acc_reg == $past(acc_reg) + $past(step_up))
    else $error("attack step wrong");
  a_step_down: assert property (state_reg == AGC_ST_APPLY && agc_on && !rst_pend_reg
      && est_sel_reg < ref_reg && acc_reg >= step_dn
      |=> acc_reg == $past(acc_reg) - $past(step_dn))
    else $error("decay step wrong");
  a_sat_low: assert property (state_reg == AGC_ST_APPLY && agc_on && !rst_pend_reg
      && est_sel_reg < ref_reg && acc_reg < step_dn |=> acc_reg == 24'h000000)
    else $error("attenuation wrapped below zero");
  a_reset_weight: assert property (state_reg == AGC_ST_APPLY && agc_on && rst_pend_reg
      && est_sel_reg < ref_reg && acc_reg >= step_dn
      && 32'(acc_reg - step_dn) + (32'(RSTW0) << rst_code) <= 32'(ACC_MAX)
      |=> 32'(acc_reg) == 32'($past(acc_reg) - $past(step_dn))
          + (32'(RSTW0) << $past(rst_code)))
    else $error("reset event weighting wrong");
  a_est_select: assert property (state_reg == AGC_ST_CMP && dg_en
      |=> est_sel_reg >= $past(est1_reg) && est_sel_reg >= $past(est2_reg))
    else $error("larger estimate not selected");
  a_unity_gain: assert property (adv && g_reg == `AGC_GAIN_UNITY
      |=> s1_data[0] == $past(samp_in_i))
    else $error("unity gain changed sample");
  a_gain_four: assert property (adv && g_reg == `AGC_GAIN_FOUR && samp_in_i[23:21] == 3'b000
      |=> s1_data[0] == {$past(samp_in_i[21:0]), 2'b00})
    else $error("gain four not a two-bit shift");
  a_dac_track: assert property ($stable(analog_reg) |-> gain_dac_code == analog_reg[13:6])
    else $error("gain DAC code not tracking");
  a_fast_pin: assert property (##1 fast_acquire_out == $past(ctrl_reg[`AGC_FAST_BIT]))
    else $error("fast acquire pin not following bit");

  c_attack: cover property (state_reg == AGC_ST_APPLY && agc_on && est_sel_reg > ref_reg);
  c_decay: cover property (state_reg == AGC_ST_APPLY && agc_on && est_sel_reg < ref_reg);
  c_reset_evt: cover property (state_reg == AGC_ST_APPLY && agc_on && rst_pend_reg);
  c_fifo_full: cover property (s2_valid[0] && !samp_in_ready);
endmodule

/* File: bench/agc_loop_top_tb.sv */
// Self-checking bench for the gain control loop top
`timescale 1ns/1ps
module agc_loop_top_tb;
  import agc_pkg::*;
  localparam int DEPTH = 32;
  logic               clk_sys       = 1'b0;
  logic               resetn        = 1'b0;
  logic               reg_wr_en     = 1'b0;
  logic [7:0]         reg_addr      = 8'h00;
  logic [7:0]         reg_wdata     = 8'h00;
  logic [7:0]         reg_rdata;
  logic               first_decimation_stage_valid    = 1'b0;
  logic signed [15:0] first_decimation_stage_i        = 16'h0000;
  logic signed [15:0] first_decimation_stage_q        = 16'h0000;
  logic               adc_reset_evt = 1'b0;
  logic               samp_in_valid = 1'b0;
  agc_samp_t          samp_in_i     = 24'h000000;
  agc_samp_t          samp_in_q     = 24'h000000;
  logic               samp_in_ready;
  logic               out_valid;
  agc_out_t           out_i;
  agc_out_t           out_q;
  logic               out_ready     = 1'b0;
  logic [7:0]         gain_dac_code;
  logic               fast_acquire_out;
  logic               mixer_mixer_attenuator_enable_out;
  int                 mismatches    = 0;
  int                 tests_run     = 0;
  int                 seq           = 1;
  logic [15:0]        exp_q[$];

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // Short counts keep the run brief
  agc_loop_top #(
    .ATTACK_CYC_A0 (60000),
    .RST_LOW_CYC   (600),
    .FIFO_DEPTH    (DEPTH)
  ) agc_loop_top_inst (
    .clk_sys          (clk_sys),
    .resetn           (resetn),
    .reg_wr_en        (reg_wr_en),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_rdata        (reg_rdata),
    .first_decimation_stage_valid       (first_decimation_stage_valid),
    .first_decimation_stage_i           (first_decimation_stage_i),
    .first_decimation_stage_q           (first_decimation_stage_q),
    .adc_reset_evt    (adc_reset_evt),
    .samp_in_valid    (samp_in_valid),
    .samp_in_i        (samp_in_i),
    .samp_in_q        (samp_in_q),
    .samp_in_ready    (samp_in_ready),
    .out_valid        (out_valid),
    .out_i            (out_i),
    .out_q            (out_q),
    .out_ready        (out_ready),
    .gain_dac_code    (gain_dac_code),
    .fast_acquire_out (fast_acquire_out),
    .mixer_mixer_attenuator_enable_out  (mixer_mixer_attenuator_enable_out)
  );

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_ok(input string nm, input logic c);
    tests_run++;
    if (c !== 1'b1)
    begin
      mismatches++;
      $display("Error %s expected 1 seen %b", nm, c);
    end
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask
  // Read data lags the address by one edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
  // Reread until both halves agree, a loop update may split them
  task automatic rdw(output logic [14:0] w);
    logic [7:0] h, l, h2;
    for (int k = 0; k < 4; k++)
    begin
      rd(8'h03, h);
      rd(8'h04, l);
      rd(8'h03, h2);
      w = {h[6:0], l};
      if (h2 === h)
        break;
    end
  endtask

  // Streams samples with valid held up; stops after 20 refused cycles
  task automatic push_n(input int n, input bit g4, output int got);
    agc_samp_t v;
    int        idle;
    got = 0;
    idle = 0;
    while (got < n && idle < 20)
    begin
      v = 24'(seq * 1024);
      @(posedge clk_sys);
      samp_in_valid <= 1'b1;
      samp_in_i     <= v;
      samp_in_q     <= -v;
      @(negedge clk_sys);
      if (samp_in_ready === 1'b1)
      begin
        exp_q.push_back(g4 ? v[21:6] : v[23:8]);
        exp_q.push_back(g4 ? (-v) >>> 6 : (-v) >>> 8);
        got++;
        seq++;
        idle = 0;
      end
      else
        idle++;
    end
    @(posedge clk_sys);
    samp_in_valid <= 1'b0;
  endtask
  task automatic drain(input int n);
    int          seen;
    int          idle;
    logic [15:0] ei, eq;
    seen = 0;
    idle = 0;
    @(posedge clk_sys);
    out_ready <= 1'b1;
    while (seen < n && idle < 40)
    begin
      @(negedge clk_sys);
      if (out_valid === 1'b1)
      begin
        ei = exp_q.pop_front();
        eq = exp_q.pop_front();
        chk16("out_i", ei, out_i);
        chk16("out_q", eq, out_q);
        seen++;
        idle = 0;
      end
      else
        idle++;
    end
    @(posedge clk_sys);
    out_ready <= 1'b0;
    chk_ok("drain count", seen == n);
  endtask

  // Reset values, readback, unmapped places, direct outputs
  task automatic t_regs;
    logic [7:0] d;
    for (int a = 3; a <= 7; a++)
    begin
      rd(8'(a), d);
      chk8("reset value", 8'h00, d);
    end
    wr(8'h03, 8'h85);
    wr(8'h04, 8'h5a);
    wr(8'h05, 8'ha3);
    wr(8'h06, 8'h48);
    wr(8'h07, 8'hff);
    wr(8'h00, 8'hff);
    rd(8'h03, d);
    chk8("reg 03", 8'h85, d);
    rd(8'h04, d);
    chk8("reg 04", 8'h5a, d);
    rd(8'h05, d);
    chk8("reg 05", 8'ha3, d);
    rd(8'h06, d);
    chk8("reg 06", 8'h48, d);
    rd(8'h07, d);
    chk8("unmapped 07", 8'h00, d);
    rd(8'h00, d);
    chk8("unmapped 00", 8'h00, d);
    chk_ok("fast acquire", fast_acquire_out === 1'b1);
    chk_ok("mixer mixer_attenuator_enable", mixer_mixer_attenuator_enable_out === 1'b1);
    chk8("gain dac", 8'h15, gain_dac_code);
    wr(8'h06, 8'h40);
    repeat (2) @(posedge clk_sys);
    chk_ok("fast acquire off", fast_acquire_out === 1'b0);
  endtask

  // Unity gain, then gain four and one with the digital stage on
  task automatic t_path;
    logic [7:0] ctl[3] = '{8'h00, 8'h80, 8'h80};
    logic [7:0] hi[3]  = '{8'h00, 8'h00, 8'h40};
    bit         g4[3]  = '{1'b0, 1'b1, 1'b0};
    int         got;
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h06, ctl[k]);
      wr(8'h03, hi[k]);
      wr(8'h04, 8'h00);
      repeat (4) @(posedge clk_sys);
      push_n(4, g4[k], got);
      drain(4);
    end
  endtask

  // Fill until refused with the consumer stalled, then empty in order
  task automatic t_fill;
    int got;
    wr(8'h06, 8'h00);
    push_n(60, 1'b0, got);
    chk_ok("fifo fill", got >= DEPTH && got <= DEPTH + 4);
    drain(got);
    @(negedge clk_sys);
    chk_ok("fifo empty", out_valid === 1'b0);
  endtask

  // Loud negative input raises attenuation to the top, silence lowers it
  task automatic t_loop;
    logic [14:0] w0, w1, wa, wb, wc;
    logic [7:0]  prev;
    int          chg;
    wr(8'h05, 8'hf0);
    wr(8'h06, 8'h01);
    @(posedge clk_sys);
    first_decimation_stage_valid <= 1'b1;
    first_decimation_stage_i     <= -16'sh7fff;
    first_decimation_stage_q     <= -16'sh7fff;
    rdw(w0);
    repeat (300) @(posedge clk_sys);
    rdw(w1);
    chk_ok("attack rises", w1 > w0);
    repeat (8000) @(posedge clk_sys);
    rdw(wa);
    repeat (300) @(posedge clk_sys);
    rdw(wb);
    chk16("top saturate", 16'h7fff, {1'b0, wb});
    chk_ok("no wrap", wa === wb);
    chk8("dac at top", 8'hff, gain_dac_code);
    @(posedge clk_sys);
    first_decimation_stage_i <= 16'sh0000;
    first_decimation_stage_q <= 16'sh0000;
    reg_addr <= 8'h04;
    repeat (2) @(posedge clk_sys);
    #1 prev = reg_rdata;
    chg = 0;
    for (int k = 0; k < 240; k++)
    begin
      @(posedge clk_sys);
      #1 if (reg_rdata !== prev) chg++;
      prev = reg_rdata;
    end
    chk_ok("update rate", chg >= 1 && chg <= 5);
    rdw(wc);
    chk_ok("decay falls", wc < wb);
    @(posedge clk_sys);
    first_decimation_stage_valid <= 1'b0;
  endtask

  // Three reset events at the lowest and highest weighting
  task automatic t_rst_evt;
    logic [14:0] w, wlo;
    for (int c = 0; c < 8; c += 7)
    begin
      do_reset();
      wr(8'h05, 8'h0f);
      wr(8'h06, {1'b0, 3'(c), 4'h1});
      repeat (200) @(posedge clk_sys);
      rdw(w);
      chk16("floor saturate", 16'h0000, {1'b0, w});
      repeat (3)
      begin
        @(posedge clk_sys);
        adc_reset_evt <= 1'b1;
        @(posedge clk_sys);
        adc_reset_evt <= 1'b0;
        repeat (58) @(posedge clk_sys);
      end
      repeat (60) @(posedge clk_sys);
      rdw(w);
      if (c == 0)
        wlo = w;
    end
    chk_ok("low weight adds", wlo > 0);
    chk_ok("high weight larger", w > wlo);
  endtask

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    $display("Error watchdog expected finish seen timeout");
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_path();
    t_fill();
    t_loop();
    t_rst_evt();
    close_out();
  end
endmodule
